/* logic/tpc_params.svh */
/*
  Constants for the timer/pin configuration and oscillator trim register bank.
  Assumes inclusion by bare name from design files; definitions only.
*/
// Functional notes
// - Timer/pin config is 8-bit, write-only, loaded only by the load instruction.
// - Any reset sets every timer/pin config bit to one.
// - Direction bit zero (output) disables that pin's wake-up and pull-up.
// - Timer clock source bit one forces pin 2 to act as input.
// - Bit 7 zero enables pin-change wake-up on pins 0, 1, 3.
// - Bit 6 zero enables weak pull-ups on pins 0, 1, 3.
// - Bit 5 one counts external clock pin, zero counts instruction cycle clock.
// - Bit 4 one counts falling edges, zero rising edges, of external pin.
// - Ratio codes 0-7 give timer 1:2..1:256, watchdog 1:1..1:128.
// - Trim register tunes 4 MHz oscillator; fine field in bits 7 to 4.
// - Fast bit 3 raises frequency, slow bit 2 lowers; zero means no change.
// - Fast and slow both set: only raise frequency, fast wins.
// - Trim bits 1 and 0 are unimplemented, read zero, ignore writes.
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// ------------------------------------------------------------------
// Register map and reset values
// ------------------------------------------------------------------
`define TPC_TRIM_ADDR 8'h8F
`define TPC_CFG_RESET 8'hFF
`define TPC_TRIM_RESET 8'h70
`define TPC_TRIM_WMASK 8'hFC
`define TPC_TRIM_FINE_RESET 4'h7
`define TPC_WDT_SHIFT_RESET 4'h7

// ------------------------------------------------------------------
// Field positions of the timer/pin config register
// ------------------------------------------------------------------
`define TPC_CFG_WAKE_DIS 7
`define TPC_CFG_PULL_DIS 6
`define TPC_CFG_CLK_SEL 5
`define TPC_CFG_EDGE_SEL 4
`define TPC_CFG_PSC_ASSIGN 3
`define TPC_CFG_RATIO_HI 2
`define TPC_CFG_RATIO_LO 0

// ------------------------------------------------------------------
// Field positions of the trim register
// ------------------------------------------------------------------
`define TPC_TRIM_FINE_HI 7
`define TPC_TRIM_FINE_LO 4
`define TPC_TRIM_FAST 3
`define TPC_TRIM_SLOW 2

// ------------------------------------------------------------------
// Pins and timing
// ------------------------------------------------------------------
`define TPC_NUM_PINS 6
`define TPC_WAKE_PIN_MASK 6'h0B
`define TPC_T0_PIN 2
`define TPC_CYCLE_DIV 4
`define TPC_SHIFT_ZERO 4'h0
`define TPC_TIMER_SHIFT_BASE 4'h1

`endif

/* logic/tpc_pkg.sv */
/*
  Types shared by the timer/pin config and trim register bank.
  Assumes constants come from tpc_params.svh.
*/
`default_nettype none
package tpc_pkg;
  typedef logic [7:0] tpc_byte_t;
  typedef logic [3:0] tpc_shift_t;
  typedef enum logic {TPC_PSC_TIMER, TPC_PSC_WDT} tpc_psc_owner_t;
endpackage
`default_nettype wire

/* logic/tpc_cycle_div.sv */
/*
  Instruction cycle enable: one pulse every DIV core clocks.
  Assumes core clock is the oscillator clock; one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tpc_params.svh"
module tpc_cycle_div #(
  parameter int DIV = `TPC_CYCLE_DIV
) (
  input wire logic clk,
  input wire logic rst,
  output logic cyc_en
);
  logic [$clog2(DIV)-1:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      cyc_en <= 1'b0;
    end else begin
      cyc_en <= (count == ($clog2(DIV))'(DIV - 1));
      count <= (count == ($clog2(DIV))'(DIV - 1)) ? '0 : count + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* logic/tpc_edge_sync.sv */
/*
  Two-flop synchroniser with selectable edge detector for the external timer clock pin.
  Assumes the pin is asynchronous to the core clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tpc_edge_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic fall_sel,
  output logic edge_seen
);
  logic meta;
  logic sync;
  logic prev;

  // First flop feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  always_comb begin
    if (fall_sel) begin
      edge_seen = prev & ~sync;
    end else begin
      edge_seen = ~prev & sync;
    end
  end
endmodule
`default_nettype wire

/* logic/tpc_regs.sv */
/*
  Timer/pin configuration register and oscillator trim register, with their
  decoded controls for the port, timer, watchdog prescaler and oscillator.
  Assumes the core drives load strobes and file-register accesses on CORE_CLK,
  and that pin directions come from the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tpc_params.svh"
module tpc_regs #(
  parameter int NUM_PINS = `TPC_NUM_PINS,
  parameter int CYCLE_DIV = `TPC_CYCLE_DIV
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CFG_LOAD,
  input wire logic [7:0] W_DATA,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [NUM_PINS-1:0] PIN_DIR,
  input wire logic TIMER_EXT_CLOCK_PIN,
  output logic [NUM_PINS-1:0] PIN_WAKE_EN,
  output logic [NUM_PINS-1:0] PIN_PULLUP_EN,
  output logic [NUM_PINS-1:0] PIN_DIR_EFF,
  output logic TIMER_CLOCK_SELECT,
  output logic TIMER_EDGE_SELECT,
  output logic TIMER_TICK,
  output logic PRESCALER_ASSIGN,
  output logic [3:0] TIMER_PSC_SHIFT,
  output logic [3:0] WDT_PSC_SHIFT,
  output logic [3:0] TRIM_FINE,
  output logic TRIM_FASTER,
  output logic TRIM_SLOWER
);
  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  tpc_pkg::tpc_byte_t timer_pin_config;
  tpc_pkg::tpc_byte_t oscillator_trim;
  logic trim_hit;
  logic cyc_en;
  logic ext_edge;
  logic [2:0] prescaler_ratio;
  tpc_pkg::tpc_psc_owner_t psc_owner;
  tpc_pkg::tpc_shift_t next_timer_shift;
  tpc_pkg::tpc_shift_t next_wdt_shift;
  logic [NUM_PINS-1:0] next_wake;
  logic [NUM_PINS-1:0] next_pull;
  logic [NUM_PINS-1:0] next_dir;

  assign trim_hit = (REG_ADDR == `TPC_TRIM_ADDR);
  assign prescaler_ratio = timer_pin_config[`TPC_CFG_RATIO_HI:`TPC_CFG_RATIO_LO];
  assign psc_owner = timer_pin_config[`TPC_CFG_PSC_ASSIGN] ?
                     tpc_pkg::TPC_PSC_WDT : tpc_pkg::TPC_PSC_TIMER;

  // ------------------------------------------------------------------
  // Timer/pin config: write-only, load instruction only
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      timer_pin_config <= `TPC_CFG_RESET;
    end else if (CFG_LOAD) begin
      timer_pin_config <= W_DATA;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator trim register
  // ------------------------------------------------------------------
  // Low two bits never store, so they cannot read back as one
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      oscillator_trim <= `TPC_TRIM_RESET;
    end else if (REG_WR && trim_hit) begin
      oscillator_trim <= REG_WDATA & `TPC_TRIM_WMASK;
    end
  end

  // Only the trim register answers reads; the config register has no read path
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD && trim_hit;
      if (REG_RD && trim_hit) begin
        REG_RDATA <= oscillator_trim & `TPC_TRIM_WMASK;
      end
    end
  end

  // ------------------------------------------------------------------
  // Per-pin wake-up, pull-up and effective direction
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
      // Only the lowest bit of the shifted mask belongs to this pin
      localparam logic ELIGIBLE = 1'(`TPC_WAKE_PIN_MASK >> gi);
      // An output pin never pulls up or wakes the core
      assign next_wake[gi] = ELIGIBLE & PIN_DIR[gi] &
                             ~timer_pin_config[`TPC_CFG_WAKE_DIS];
      assign next_pull[gi] = ELIGIBLE & PIN_DIR[gi] &
                             ~timer_pin_config[`TPC_CFG_PULL_DIS];
      if (gi == `TPC_T0_PIN) begin : g_t0
        assign next_dir[gi] = PIN_DIR[gi] | timer_pin_config[`TPC_CFG_CLK_SEL];
      end else begin : g_plain
        assign next_dir[gi] = PIN_DIR[gi];
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PIN_WAKE_EN <= '0;
      PIN_PULLUP_EN <= '0;
      PIN_DIR_EFF <= '1;
    end else begin
      PIN_WAKE_EN <= next_wake;
      PIN_PULLUP_EN <= next_pull;
      PIN_DIR_EFF <= next_dir;
    end
  end

  // ------------------------------------------------------------------
  // Prescaler assignment and ratio as shift counts
  // ------------------------------------------------------------------
  // The side not owning the prescaler runs at 1:1
  always_comb begin
    next_timer_shift = `TPC_SHIFT_ZERO;
    next_wdt_shift = `TPC_SHIFT_ZERO;
    unique case (psc_owner)
      tpc_pkg::TPC_PSC_TIMER: begin
        next_timer_shift = `TPC_TIMER_SHIFT_BASE + {1'b0, prescaler_ratio};
      end
      tpc_pkg::TPC_PSC_WDT: begin
        next_wdt_shift = {1'b0, prescaler_ratio};
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRESCALER_ASSIGN <= 1'b1;
      TIMER_PSC_SHIFT <= `TPC_SHIFT_ZERO;
      WDT_PSC_SHIFT <= `TPC_WDT_SHIFT_RESET;
    end else begin
      PRESCALER_ASSIGN <= timer_pin_config[`TPC_CFG_PSC_ASSIGN];
      TIMER_PSC_SHIFT <= next_timer_shift;
      WDT_PSC_SHIFT <= next_wdt_shift;
    end
  end

  // ------------------------------------------------------------------
  // Timer clock source and edge
  // ------------------------------------------------------------------
  tpc_cycle_div #(
    .DIV(CYCLE_DIV)
  ) u_div (
    .clk(CORE_CLK),
    .rst(RST),
    .cyc_en(cyc_en)
  );

  tpc_edge_sync u_edge (
    .clk(CORE_CLK),
    .rst(RST),
    .pin(TIMER_EXT_CLOCK_PIN),
    .fall_sel(timer_pin_config[`TPC_CFG_EDGE_SEL]),
    .edge_seen(ext_edge)
  );

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      TIMER_CLOCK_SELECT <= 1'b1;
      TIMER_EDGE_SELECT <= 1'b1;
      TIMER_TICK <= 1'b0;
    end else begin
      TIMER_CLOCK_SELECT <= timer_pin_config[`TPC_CFG_CLK_SEL];
      TIMER_EDGE_SELECT <= timer_pin_config[`TPC_CFG_EDGE_SEL];
      TIMER_TICK <= timer_pin_config[`TPC_CFG_CLK_SEL] ? ext_edge : cyc_en;
    end
  end

  // ------------------------------------------------------------------
  // Oscillator trim outputs
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      TRIM_FINE <= `TPC_TRIM_FINE_RESET;
      TRIM_FASTER <= 1'b0;
      TRIM_SLOWER <= 1'b0;
    end else begin
      TRIM_FINE <= oscillator_trim[`TPC_TRIM_FINE_HI:`TPC_TRIM_FINE_LO];
      TRIM_FASTER <= oscillator_trim[`TPC_TRIM_FAST];
      // Fast has precedence, so slow is dropped when both are set
      TRIM_SLOWER <= oscillator_trim[`TPC_TRIM_SLOW] &
                     ~oscillator_trim[`TPC_TRIM_FAST];
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_CFG_LOAD: assert property (
    CFG_LOAD |=> (timer_pin_config == $past(W_DATA)))
    else $error("Config register did not take the working value");

  AST_CFG_HOLD: assert property (
    !CFG_LOAD |=> $stable(timer_pin_config))
    else $error("Config register changed without a load");

  AST_CFG_RESET: assert property (
    $fell(RST) |-> (timer_pin_config == `TPC_CFG_RESET))
    else $error("Config register not all ones after reset");

  AST_OUT_PIN_NO_PULL: assert property (
    !PIN_DIR[0] |=> !PIN_PULLUP_EN[0] && !PIN_WAKE_EN[0])
    else $error("Output pin still has pull-up or wake-up");

  AST_T0_FORCE_IN: assert property (
    timer_pin_config[`TPC_CFG_CLK_SEL] |=> PIN_DIR_EFF[`TPC_T0_PIN])
    else $error("Pin 2 not forced to input");

  AST_WAKE_EN: assert property (
    (PIN_DIR[1] && !timer_pin_config[`TPC_CFG_WAKE_DIS]) |=> PIN_WAKE_EN[1])
    else $error("Wake-up not enabled on eligible input pin");

  AST_PULL_EN: assert property (
    (PIN_DIR[3] && !timer_pin_config[`TPC_CFG_PULL_DIS]) |=>
      PIN_PULLUP_EN[3] && !PIN_PULLUP_EN[`TPC_T0_PIN])
    else $error("Pull-up enable wrong");

  AST_INT_TICK: assert property (
    (!timer_pin_config[`TPC_CFG_CLK_SEL] && cyc_en) ##1 !timer_pin_config[`TPC_CFG_CLK_SEL]
      |-> TIMER_TICK ##1 !TIMER_TICK)
    else $error("Internal cycle tick missing");

  AST_EXT_TICK: assert property (
    (timer_pin_config[`TPC_CFG_CLK_SEL] && ext_edge) |=> TIMER_TICK)
    else $error("External edge tick missing");

  // Internal cycle pulses must not leak while the pin is the source
  AST_EXT_ONLY: assert property (
    (timer_pin_config[`TPC_CFG_CLK_SEL] && !ext_edge) |=> !TIMER_TICK)
    else $error("Timer ticked without a selected pin edge");

  AST_EDGE_SEL: assert property (
    !CFG_LOAD |=> TIMER_EDGE_SELECT == timer_pin_config[`TPC_CFG_EDGE_SEL])
    else $error("Edge select output wrong");

  AST_PSC_ONE_OWNER: assert property (
    (TIMER_PSC_SHIFT == 4'h0) || (WDT_PSC_SHIFT == 4'h0))
    else $error("Prescaler serves both timer and watchdog");

  AST_TIMER_RATIO: assert property (
    (!timer_pin_config[`TPC_CFG_PSC_ASSIGN] && !CFG_LOAD) |=>
      TIMER_PSC_SHIFT == 4'(timer_pin_config[`TPC_CFG_RATIO_HI:`TPC_CFG_RATIO_LO]) + 4'h1)
    else $error("Timer ratio wrong");

  AST_WDT_RATIO: assert property (
    (timer_pin_config[`TPC_CFG_PSC_ASSIGN] && !CFG_LOAD) |=>
      WDT_PSC_SHIFT == 4'(timer_pin_config[`TPC_CFG_RATIO_HI:`TPC_CFG_RATIO_LO])
      && TIMER_PSC_SHIFT == 4'h0)
    else $error("Watchdog ratio wrong");

  AST_TRIM_STORE: assert property (
    (REG_WR && trim_hit) |=> oscillator_trim[`TPC_TRIM_FINE_HI:`TPC_TRIM_FINE_LO] ==
      $past(REG_WDATA[`TPC_TRIM_FINE_HI:`TPC_TRIM_FINE_LO]))
    else $error("Fine trim not stored");

  AST_TRIM_FAST: assert property (
    oscillator_trim[`TPC_TRIM_FAST] |=> TRIM_FASTER)
    else $error("Fast trim not applied");

  AST_TRIM_SLOW: assert property (
    (oscillator_trim[`TPC_TRIM_SLOW] && !oscillator_trim[`TPC_TRIM_FAST]) |=> TRIM_SLOWER)
    else $error("Slow trim not applied");

  AST_TRIM_NO_CHANGE: assert property (
    (!oscillator_trim[`TPC_TRIM_FAST] && !oscillator_trim[`TPC_TRIM_SLOW]) |=>
      !TRIM_FASTER && !TRIM_SLOWER)
    else $error("Trim moved with both bits clear");

  AST_TRIM_PRECEDENCE: assert property (
    (oscillator_trim[`TPC_TRIM_FAST] && oscillator_trim[`TPC_TRIM_SLOW]) |=>
      TRIM_FASTER && !TRIM_SLOWER)
    else $error("Fast trim lost precedence");

  AST_TRIM_LOW_ZERO: assert property (
    (oscillator_trim & ~`TPC_TRIM_WMASK) == 8'h00)
    else $error("Unimplemented trim bits hold a one");

  AST_TRIM_READ: assert property (
    (REG_RD && trim_hit) |=> REG_RVALID && ((REG_RDATA & ~`TPC_TRIM_WMASK) == 8'h00)
      && (REG_RDATA == $past(oscillator_trim)))
    else $error("Trim readback wrong");

  AST_NO_CFG_READ: assert property (
    !(REG_RD && trim_hit) |=> !REG_RVALID)
    else $error("Read answered outside the trim register");

  COV_CFG_LOAD: cover property (CFG_LOAD ##1 !timer_pin_config[`TPC_CFG_CLK_SEL]);
  COV_EXT_TICK: cover property (timer_pin_config[`TPC_CFG_CLK_SEL] && TIMER_TICK);
  COV_TRIM_BOTH: cover property (TRIM_FASTER && oscillator_trim[`TPC_TRIM_SLOW]);
  COV_WDT_OWNER: cover property (!timer_pin_config[`TPC_CFG_PSC_ASSIGN] ##[1:20]
    timer_pin_config[`TPC_CFG_PSC_ASSIGN]);
endmodule
`default_nettype wire

/* testbench/tb_timer_config_and_osc_trim_regs.sv */
/*
  Self-checking bench for the timer/pin config and oscillator trim registers.
  Assumes tpc_regs with default parameters and its assertions built in.
*/
`timescale 1ns/100ps
`default_nettype none
`include "tpc_params.svh"
module tb_timer_config_and_osc_trim_regs;
  logic CORE_CLK, RST, CFG_LOAD, REG_WR, REG_RD, TIMER_EXT_CLOCK_PIN;
  logic [7:0] W_DATA, REG_ADDR, REG_WDATA, REG_RDATA;
  logic [5:0] PIN_DIR, PIN_WAKE_EN, PIN_PULLUP_EN, PIN_DIR_EFF;
  logic REG_RVALID, TIMER_CLOCK_SELECT, TIMER_EDGE_SELECT, TIMER_TICK, PRESCALER_ASSIGN;
  logic [3:0] TIMER_PSC_SHIFT, WDT_PSC_SHIFT, TRIM_FINE;
  logic TRIM_FASTER, TRIM_SLOWER;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int ticks = 0;

  tpc_regs uut (.CORE_CLK(CORE_CLK), .RST(RST), .CFG_LOAD(CFG_LOAD), .W_DATA(W_DATA),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .PIN_DIR(PIN_DIR),
    .TIMER_EXT_CLOCK_PIN(TIMER_EXT_CLOCK_PIN), .PIN_WAKE_EN(PIN_WAKE_EN),
    .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_DIR_EFF(PIN_DIR_EFF),
    .TIMER_CLOCK_SELECT(TIMER_CLOCK_SELECT), .TIMER_EDGE_SELECT(TIMER_EDGE_SELECT),
    .TIMER_TICK(TIMER_TICK), .PRESCALER_ASSIGN(PRESCALER_ASSIGN),
    .TIMER_PSC_SHIFT(TIMER_PSC_SHIFT), .WDT_PSC_SHIFT(WDT_PSC_SHIFT),
    .TRIM_FINE(TRIM_FINE), .TRIM_FASTER(TRIM_FASTER), .TRIM_SLOWER(TRIM_SLOWER));

  // ------------------------------------------------------------------
  // Clock, tick count and hang guard
  // ------------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  // Whole run needs well under 2000 cycles
  always @(posedge CORE_CLK) begin
    cycles++;
    if (TIMER_TICK === 1'b1) ticks++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task expect_cfg(input logic [7:0] v);
    check("wake", {2'b00, PIN_WAKE_EN}, v[7] ? 8'h00 : {2'b00, PIN_DIR & 6'h0B});
    check("pull", {2'b00, PIN_PULLUP_EN}, v[6] ? 8'h00 : {2'b00, PIN_DIR & 6'h0B});
    check("dir_eff", {2'b00, PIN_DIR_EFF}, {2'b00, PIN_DIR | {3'b000, v[5], 2'b00}});
    check("clk_sel", {7'h00, TIMER_CLOCK_SELECT}, {7'h00, v[5]});
    check("edge_sel", {7'h00, TIMER_EDGE_SELECT}, {7'h00, v[4]});
    check("assign", {7'h00, PRESCALER_ASSIGN}, {7'h00, v[3]});
    check("t_shift", {4'h0, TIMER_PSC_SHIFT}, v[3] ? 8'h00 : {5'h00, v[2:0]} + 8'h01);
    check("w_shift", {4'h0, WDT_PSC_SHIFT}, v[3] ? {5'h00, v[2:0]} : 8'h00);
  endtask

  task expect_trim(input logic [7:0] d);
    check("fine", {4'h0, TRIM_FINE}, {4'h0, d[7:4]});
    check("faster", {7'h00, TRIM_FASTER}, {7'h00, d[3]});
    check("slower", {7'h00, TRIM_SLOWER}, {7'h00, d[2] & ~d[3]});
  endtask

  task cfg_load(input logic [7:0] v, input logic [5:0] dir);
    @(posedge CORE_CLK);
    CFG_LOAD <= 1'b1;
    W_DATA <= v;
    PIN_DIR <= dir;
    @(posedge CORE_CLK);
    CFG_LOAD <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    expect_cfg(v);
  endtask

  task trim_wr(input logic [7:0] addr, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= addr;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    @(posedge CORE_CLK);
    // Trim outputs settle after this edge, not in its time step
    #1;
  endtask

  task trim_rd(input logic [7:0] addr, input logic ok, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= addr;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1;
    check("rvalid", {7'h00, REG_RVALID}, {7'h00, ok});
    check("rdata", REG_RDATA, exp);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task test_reset();
    @(posedge CORE_CLK);
    PIN_DIR <= 6'h3F;
    RST <= 1'b1;
    @(posedge CORE_CLK);
    #1;
    expect_cfg(`TPC_CFG_RESET);
    expect_trim(`TPC_TRIM_RESET);
    @(posedge CORE_CLK);
    RST <= 1'b0;
    $display("test reset done");
  endtask

  task test_cfg_fields();
    logic [3:0] k;
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      cfg_load({k[0], k[1], k[2], ~k[0], k[3], k[2:0]}, k[1] ? 6'h31 : 6'h0E);
    end
    $display("test cfg_fields done");
  endtask

  task test_trim();
    trim_rd(`TPC_TRIM_ADDR, 1'b1, `TPC_TRIM_RESET);
    trim_wr(`TPC_TRIM_ADDR, 8'hFF);
    expect_trim(8'hFC);
    trim_rd(`TPC_TRIM_ADDR, 1'b1, 8'hFC);
    trim_wr(`TPC_TRIM_ADDR, 8'h57);
    expect_trim(8'h54);
    trim_rd(`TPC_TRIM_ADDR, 1'b1, 8'h54);
    trim_wr(`TPC_TRIM_ADDR, 8'h88);
    expect_trim(8'h88);
    // Unmapped place must neither store nor answer
    trim_wr(8'h8E, 8'h00);
    expect_trim(8'h88);
    // Read data still holds the last trim read
    trim_rd(8'h8E, 1'b0, 8'h54);
    trim_rd(`TPC_TRIM_ADDR, 1'b1, 8'h88);
    $display("test trim done");
  endtask

  task test_int_tick();
    cfg_load(8'hC8, 6'h3F);
    repeat (8) @(posedge CORE_CLK);
    #1;
    ticks = 0;
    repeat (40) @(posedge CORE_CLK);
    #1;
    check("int_ticks", 8'(ticks), 8'(40 / `TPC_CYCLE_DIV));
    $display("test int_tick done");
  endtask

  task test_ext_tick(input logic fall);
    cfg_load({3'b111, fall, 4'h8}, 6'h3F);
    repeat (8) @(posedge CORE_CLK);
    #1;
    ticks = 0;
    @(posedge CORE_CLK);
    TIMER_EXT_CLOCK_PIN <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    #1;
    check("rise_ticks", 8'(ticks), fall ? 8'h00 : 8'h01);
    @(posedge CORE_CLK);
    TIMER_EXT_CLOCK_PIN <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    #1;
    check("fall_ticks", 8'(ticks), 8'h01);
    $display("test ext_tick done");
  endtask

  task test_done();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    RST = 1'b1;
    CFG_LOAD = 1'b0;
    W_DATA = 8'h00;
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 8'h00;
    PIN_DIR = 6'h3F;
    TIMER_EXT_CLOCK_PIN = 1'b0;
    test_reset();
    test_cfg_fields();
    test_trim();
    test_int_tick();
    test_ext_tick(1'b0);
    test_ext_tick(1'b1);
    // Reset in mid-run restores both registers
    test_reset();
    trim_rd(`TPC_TRIM_ADDR, 1'b1, `TPC_TRIM_RESET);
    test_done();
  end
endmodule
`default_nettype wire
